// File: meter_clock_div.sv
`timescale 1ns/1ps
module meter_clock_div import meter_pkg::*; #(
  parameter int CRYS_HZ = CRYSTAL_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic master_tick,
  output logic tone
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [24:0] acc;
    logic half;
    logic [5:0] tone_cnt;
    logic tone;
    logic master_tick;
  } div_s;

  div_s r;
  div_s next_r;
  logic [24:0] sum;
  logic crystal_tick;

  // Fractional accumulator: pclk is not a multiple of the crystal
  assign sum = r.acc + 25'(CRYS_HZ);
  assign crystal_tick = (sum >= 25'(PCLK_HZ));

  always_comb begin
    next_r = r;
    next_r.master_tick = 1'b0;
    next_r.acc = crystal_tick ? 25'(sum - 25'(PCLK_HZ)) : sum;
    if (crystal_tick) begin
      next_r.half = ~r.half;
      next_r.master_tick = r.half; // [RL1]
      if (r.tone_cnt == 6'(TONE_HALF_TICKS - 1)) begin
        next_r.tone_cnt = 6'h00;
        next_r.tone = ~r.tone; // [RL19]
      end else begin
        next_r.tone_cnt = r.tone_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign master_tick = r.master_tick;
  assign tone = r.tone;

endmodule

// File: meter_front_model.sv
`timescale 1ns/1ps
module meter_front_model #(
  parameter int TICK = 4
) (
  input wire logic pclk,
  input wire logic deint,
  input wire logic [15:0] zero_ticks,
  output logic integrator_zero
);
  // ----
  // Integrator comparator
  // ----
  logic was;
  int cnt;
  int lim;
  initial begin
    was = 1'b0;
    cnt = 0;
    lim = 0;
    integrator_zero = 1'b0;
  end
  // Outside deintegrate the line flips so stale values cannot be trusted
  always @(posedge pclk) begin
    was <= deint;
    if (deint && !was) begin
      cnt <= 0;
      lim <= zero_ticks * TICK;
      integrator_zero <= 1'b0;
    end else if (deint) begin
      cnt <= cnt + 1;
      integrator_zero <= (cnt + 1 >= lim);
    end else begin
      integrator_zero <= ~integrator_zero;
    end
  end
endmodule

// File: meter_lcd_duplex.sv
`timescale 1ns/1ps
module meter_lcd_duplex import meter_pkg::*; #(
  parameter int LINES = SEG_LINES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic master_tick,
  input wire logic [LINES-1:0] seg_bp1,
  input wire logic [LINES-1:0] seg_bp2,
  output logic [1:0] bp1_level,
  output logic [1:0] bp2_level,
  output logic [LINES-1:0] seg_level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] div;
    logic [1:0] slot;
    logic [1:0] bp1;
    logic [1:0] bp2;
    logic [LINES-1:0] seg;
  } lcd_s;

  lcd_s r;
  lcd_s next_r;

  // Slot 0/1 drive plane 1 high then low, slot 2/3 plane 2; the idle
  // plane sits at mid. Each segment spends equal time high and low,
  // so no DC builds up across the glass.
  always_comb begin
    logic bp_high;
    logic [LINES-1:0] on;
    bp_high = 1'b0;
    on = '0;
    next_r = r;
    if (master_tick) begin
      if (r.div == 7'(LCD_SLOT_TICKS - 1)) begin
        next_r.div = 7'h00;
        next_r.slot = r.slot + 2'h1;
      end else begin
        next_r.div = r.div + 7'h01;
      end
    end
    bp_high = ~next_r.slot[0];
    on = next_r.slot[1] ? seg_bp2 : seg_bp1; // [RL11]
    next_r.bp1 = next_r.slot[1] ? LVL_MID : (bp_high ? LVL_HIGH : LVL_LOW); // [RL13]
    next_r.bp2 = next_r.slot[1] ? (bp_high ? LVL_HIGH : LVL_LOW) : LVL_MID; // [RL13]
    next_r.seg = on ^ {LINES{bp_high}}; // [RL13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{div: 7'h00, slot: 2'h0, bp1: LVL_MID, bp2: LVL_MID, seg: '0};
    end else begin
      r <= next_r;
    end
  end

  assign bp1_level = r.bp1;
  assign bp2_level = r.bp2;
  assign seg_level = r.seg;

endmodule

// File: meter_ohms_mode_display_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// [RL1] Internal tick is the crystal rate halved; all phases count it.
// [RL2] Crystal runs near 120 kHz for 60 Hz, 100 kHz for 50 Hz.
// [RL3] Function select: high ohms, middle or open volts, low amps.
// [RL4] Scale, subrange and hold selects decode high, middle, low as listed.
// [RL5] Ohms integrates unknown, deintegrates known resistor, current timing.
// [RL6] Low ohms uses low known resistor, high ohms the high one.
// [RL7] Continuity detector enabled only in low ohms subrange.
// [RL8] Beeper sounds while the continuity comparator reports low voltage.
// [RL9] Beeper toggles rail to rail as a square tone.
// [RL10] Beeper follows comparator with no conversion phase gating.
// [RL11] Display duplexed on two backplanes, two segments per line.
// [RL12] Drive digits, decimal points and range, polarity, battery annunciators.
// [RL13] Three level balanced waveforms keep segment DC near zero.
// [RL14] Most sensitive range integrates 10,000 internal ticks.
// [RL15] Offset null switches close each null phase, used in next integrate.
// [RL16] Only the 1000 and 10,000 tick ranges are used.
// [RL17] No zero crossing by 4000 counts sets overload and shows it.
// [RL18] Below 360 steps to finer range; else display; last range always shown.
// [RL19] Tone is crystal rate divided by 60.
// [RL20] Hold freezes the displayed reading and annunciators.
module meter_ohms_mode_display_ctrl import meter_pkg::*; #(
  parameter int INT_FINE = INT_FINE_TICKS,
  parameter int CRYS_HZ = CRYSTAL_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic function_high,
  input wire logic function_low,
  input wire logic current_scale_select_high,
  input wire logic current_scale_select_low,
  input wire logic subrange_select_high,
  input wire logic subrange_select_low,
  input wire logic hold_high,
  input wire logic hold_low,
  input wire logic integrator_zero,
  input wire logic integrator_positive,
  input wire logic continuity_below,
  input wire logic low_battery,
  output logic offset_null_phase,
  output logic integrate_input,
  output logic deintegrate_pos,
  output logic deintegrate_neg,
  output logic fine_range,
  output logic low_known_resistor,
  output logic high_known_resistor,
  output logic continuity_enable,
  output logic beeper_out,
  output logic overload_indication,
  output logic [1:0] backplane1_level,
  output logic [1:0] backplane2_level,
  output logic [SEG_LINES-1:0] segment_line
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Segments {a,b,c,d,e,f,g}; code 4'hf is an L, 4'he blank
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h7e;
      4'h1: seg7 = 7'h30;
      4'h2: seg7 = 7'h6d;
      4'h3: seg7 = 7'h79;
      4'h4: seg7 = 7'h33;
      4'h5: seg7 = 7'h5b;
      4'h6: seg7 = 7'h5f;
      4'h7: seg7 = 7'h70;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h7b;
      4'hf: seg7 = 7'h0e;
      default: seg7 = 7'h00;
    endcase
  endfunction

  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] o;
    logic carry;
    o = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        if (o[i*4 +: 4] == 4'h9) begin
          o[i*4 +: 4] = 4'h0;
        end else begin
          o[i*4 +: 4] = o[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return o;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_e phase;
    logic fine;
    logic [13:0] ticks;
    logic [15:0] bcd;
    logic positive;
    logic [15:0] reading;
    logic shown_positive;
    logic shown_overload;
    logic shown_fine;
    tern_e shown_func;
    tern_e shown_scale;
    tern_e shown_sub;
    logic shown_lowbat;
    logic display_on;
    logic [31:0] prdata;
    logic pslverr;
  } ctrl_s;

  ctrl_s r;
  ctrl_s next_r;
  tern_e func;
  tern_e scale;
  tern_e sub;
  tern_e hold;
  logic master_tick;
  logic tone;
  logic [13:0] int_last;
  logic crossing;
  logic [SEG_LINES-1:0] seg_bp1;
  logic [SEG_LINES-1:0] seg_bp2;

  assign func = tern_decode(function_high, function_low); // [RL3]
  assign scale = tern_decode(current_scale_select_high, current_scale_select_low); // [RL4]
  assign sub = tern_decode(subrange_select_high, subrange_select_low); // [RL4]
  assign hold = tern_decode(hold_high, hold_low); // [RL4]

  // Only the two most sensitive ranges are sequenced
  assign int_last = r.fine ? 14'(INT_FINE - 1) : 14'(INT_COARSE_TICKS - 1); // [RL16] [RL14]
  assign crossing = integrator_zero || (bcd_inc(r.bcd) == OVERLOAD_BCD); // [RL17]

  // ---------------------------------------------------------------
  // Sequencer and register bus
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (master_tick) begin
      next_r.ticks = r.ticks + 14'h0001;
      unique case (r.phase)
        PH_AZ: begin
          if (r.ticks == 14'(AZ_TICKS - 1)) begin
            next_r.phase = PH_INT; // [RL15]
            next_r.ticks = '0;
          end
        end
        PH_INT: begin
          if (r.ticks == int_last) begin
            next_r.phase = PH_DEINT; // [RL5]
            next_r.ticks = '0;
            next_r.bcd = '0;
            next_r.positive = integrator_positive;
          end
        end
        PH_DEINT: begin
          next_r.bcd = bcd_inc(r.bcd);
          if (crossing) begin
            next_r.phase = PH_AZ;
            next_r.ticks = '0;
            if (!integrator_zero || r.fine || r.bcd >= UNDERRANGE_BCD) begin // [RL18]
              next_r.fine = 1'b0;
              if (hold != T_HIGH) begin // [RL20]
                next_r.reading = r.bcd;
                next_r.shown_overload = !integrator_zero; // [RL17]
                next_r.shown_positive = r.positive;
                next_r.shown_fine = r.fine;
                next_r.shown_func = func;
                next_r.shown_scale = scale;
                next_r.shown_sub = sub;
                next_r.shown_lowbat = low_battery;
              end
            end else begin
              next_r.fine = 1'b1; // [RL18]
            end
          end
        end
      endcase
    end
    // Read data are captured in the setup cycle so prdata is a flop
    if (psel && !penable) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      case (paddr)
        REG_CTRL: next_r.prdata = {31'h0, r.display_on};
        REG_STATUS: next_r.prdata = {22'h0, r.shown_overload, r.fine, r.phase,
                                     hold, sub, func};
        REG_READING: next_r.prdata = {16'h0, r.reading};
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == REG_CTRL) begin
      next_r.display_on = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{phase: PH_AZ, fine: 1'b0, ticks: '0, bcd: '0, positive: 1'b1,
             reading: '0, shown_positive: 1'b1, shown_overload: 1'b0,
             shown_fine: 1'b0, shown_func: T_MID, shown_scale: T_MID,
             shown_sub: T_MID, shown_lowbat: 1'b0,
             display_on: CTRL_DISPLAY_RESET, prdata: '0, pslverr: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;

  // ---------------------------------------------------------------
  // Analog switch controls
  // ---------------------------------------------------------------
  assign offset_null_phase = (r.phase == PH_AZ); // [RL15]
  assign integrate_input = (r.phase == PH_INT); // [RL5]
  assign deintegrate_pos = (r.phase == PH_DEINT) && r.positive;
  assign deintegrate_neg = (r.phase == PH_DEINT) && !r.positive;
  assign fine_range = r.fine;
  assign low_known_resistor = (r.phase == PH_DEINT) && func == T_HIGH && sub == T_MID; // [RL6]
  assign high_known_resistor = (r.phase == PH_DEINT) && func == T_HIGH && sub == T_HIGH; // [RL6]
  assign overload_indication = r.shown_overload;

  // ---------------------------------------------------------------
  // Continuity beeper
  // ---------------------------------------------------------------
  // Idle level is the upper rail; no dependence on the phase so the
  // user hears the probe contact at once.
  assign continuity_enable = (func == T_HIGH) && (sub == T_MID); // [RL7]
  assign beeper_out = (continuity_enable && continuity_below) ? tone : 1'b1; // [RL8] [RL9] [RL10]

  // ---------------------------------------------------------------
  // Display pattern
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] digits;
    logic [6:0] s;
    logic [2:0] dp;
    digits = r.reading;
    s = '0;
    dp = '0;
    seg_bp1 = '0;
    seg_bp2 = '0;
    if (r.shown_overload) begin
      digits = 16'he0fe; // [RL17]
    end
    dp[0] = r.shown_fine && !r.shown_overload;
    dp[2] = !r.shown_fine && !r.shown_overload;
    for (int k = 0; k < 3; k++) begin
      s = seg7(digits[k*4 +: 4]);
      seg_bp1[4 + k*4 +: 4] = {s[1], s[0], s[6], s[5]}; // [RL12]
      seg_bp2[4 + k*4 +: 4] = {dp[k], s[2], s[3], s[4]}; // [RL12]
    end
    s = seg7(digits[15:12]);
    seg_bp1[17:16] = {s[6] | s[3] | s[0], s[5]};
    seg_bp2[17:16] = {s[2], s[4]};
    // Annunciators; minus sign shares the thousands upper segment
    seg_bp1[0] = r.shown_func == T_HIGH && r.shown_sub == T_MID;
    seg_bp1[1] = r.shown_func == T_HIGH;
    seg_bp1[2] = r.shown_func == T_HIGH && r.shown_sub == T_HIGH;
    seg_bp1[3] = r.shown_lowbat;
    seg_bp2[0] = r.shown_func == T_LOW && r.shown_scale == T_HIGH;
    seg_bp2[1] = r.shown_func == T_LOW;
    seg_bp2[2] = r.shown_func == T_LOW && r.shown_scale != T_HIGH;
    seg_bp2[3] = r.shown_func == T_MID;
    if (r.shown_func != T_HIGH && !r.shown_positive && !r.shown_overload) begin
      seg_bp1[16] = 1'b1;
    end
    // Blanking keeps the waveforms running so the glass stays balanced
    if (!r.display_on) begin
      seg_bp1 = '0;
      seg_bp2 = '0;
    end
  end

  // ---------------------------------------------------------------
  // Children
  // ---------------------------------------------------------------
  meter_clock_div #(.CRYS_HZ(CRYS_HZ)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .master_tick(master_tick),
    .tone(tone)
  );

  meter_lcd_duplex #(.LINES(SEG_LINES)) u_lcd (
    .pclk(pclk),
    .presetn(presetn),
    .master_tick(master_tick),
    .seg_bp1(seg_bp1),
    .seg_bp2(seg_bp2),
    .bp1_level(backplane1_level),
    .bp2_level(backplane2_level),
    .seg_level(segment_line)
  );

endmodule

// File: meter_ohms_mode_display_ctrl_tb.sv
`timescale 1ns/1ps
module meter_ohms_mode_display_ctrl_tb import meter_pkg::*;;
  localparam int CRYS = 10000000; // Raised to shorten the run
  localparam int HALF = TONE_HALF_TICKS * PCLK_HZ / CRYS;
  typedef struct packed {logic e; logic [31:0] m; logic [31:0] d;} note_s;
  note_s q[$];
  note_s nt;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, r;
  logic pready, pslverr, integrator_zero, b_prev;
  logic function_high = 0, function_low = 0, current_scale_select_high = 0;
  logic current_scale_select_low = 0, subrange_select_high = 0, subrange_select_low = 0;
  logic hold_high = 0, hold_low = 0, integrator_positive = 0, continuity_below = 0;
  logic low_battery = 0, offset_null_phase, integrate_input, deintegrate_pos, deintegrate_neg;
  logic fine_range, low_known_resistor, high_known_resistor, continuity_enable, beeper_out;
  logic overload_indication;
  logic [1:0] backplane1_level, backplane2_level;
  logic [SEG_LINES-1:0] segment_line;
  logic [15:0] zero_ticks = 16'd1000;
  integer seed = 32'hd9c7;
  int n_mismatch = 0, checks_done = 0, l, i, tog, v;
  always #25 pclk = ~pclk;
  meter_ohms_mode_display_ctrl #(.INT_FINE(200), .CRYS_HZ(CRYS)) DUT (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .function_high(function_high), .function_low(function_low),
    .current_scale_select_high(current_scale_select_high),
    .current_scale_select_low(current_scale_select_low),
    .subrange_select_high(subrange_select_high), .subrange_select_low(subrange_select_low),
    .hold_high(hold_high), .hold_low(hold_low), .integrator_zero(integrator_zero),
    .integrator_positive(integrator_positive), .continuity_below(continuity_below),
    .low_battery(low_battery), .offset_null_phase(offset_null_phase),
    .integrate_input(integrate_input), .deintegrate_pos(deintegrate_pos),
    .deintegrate_neg(deintegrate_neg), .fine_range(fine_range),
    .low_known_resistor(low_known_resistor), .high_known_resistor(high_known_resistor),
    .continuity_enable(continuity_enable), .beeper_out(beeper_out),
    .overload_indication(overload_indication), .backplane1_level(backplane1_level),
    .backplane2_level(backplane2_level), .segment_line(segment_line));
  meter_front_model #(.TICK(2 * PCLK_HZ / CRYS)) front (.pclk(pclk),
    .deint(deintegrate_pos | deintegrate_neg), .zero_ticks(zero_ticks),
    .integrator_zero(integrator_zero));
  // ----
  // Checking
  // ----
  task close_out;
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = q.pop_front();
      check("prdata", prdata & nt.m, nt.d & nt.m);
      check("pslverr", 32'(pslverr), 32'(nt.e));
    end
  end
  // ----
  // Drivers
  // ----
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] m,
    input logic e);
    int k;
    @(posedge pclk);
    q.push_back('{e, m, d});
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [1:0] pins(input int lv);
    return (lv == 0) ? 2'b10 : (lv == 1) ? 2'b00 : 2'b01;
  endfunction
  task sel(input int f, input int s, input int h);
    {function_high, function_low} <= pins(f);
    {current_scale_select_high, current_scale_select_low} <= pins(s);
    {subrange_select_high, subrange_select_low} <= pins(s);
    {hold_high, hold_low} <= pins(h);
    repeat (3) @(posedge pclk);
  endtask
  // Waits for a whole conversion of the wanted range, then a few cycles
  task wait_conv(input logic [15:0] n, input logic fine);
    zero_ticks <= n;
    r = $random(seed);
    integrator_positive <= r[0];
    low_battery <= r[1];
    for (i = 0; i < 90000 && !(integrate_input === 1'b1 && fine_range === fine); i++)
      @(posedge pclk);
    for (i = i; i < 90000 && offset_null_phase !== 1'b1; i++) @(posedge pclk);
    if (i >= 90000) begin
      n_mismatch++;
      close_out();
    end
    repeat (4) @(posedge pclk);
  endtask
  task read_val(input int n);
    apb(REG_READING, 0, 32'h0, 32'h0, 0);
    v = rd[15:12] * 1000 + rd[11:8] * 100 + rd[7:4] * 10 + rd[3:0];
    check("reading", 32'(v >= n - 2 && v <= n + 2), 32'h1);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(REG_CTRL, 0, 32'h1, 32'h1, 0);
    apb(REG_CTRL, 1, 32'h0, 32'h0, 0);
    apb(REG_CTRL, 0, 32'h0, 32'h1, 0);
    apb(REG_CTRL, 1, 32'h1, 32'h0, 0);
    apb(12'h00c, 0, 32'h0, 32'hffffffff, 1);
    apb(12'h00c, 1, 32'h5, 32'h0, 1);
    apb(REG_STATUS, 1, 32'h0, 32'h0, 0);
    for (l = 0; l < 3; l++) begin
      sel(l, l, l);
      apb(REG_STATUS, 0, (l << 4) | (l << 2) | l, 32'h3f, 0);
    end
    sel(0, 1, 1);
    continuity_below <= 1;
    repeat (3) @(posedge pclk);
    check("continuity_enable", 32'(continuity_enable), 32'h1);
    tog = 0;
    b_prev = beeper_out;
    for (l = 0; l < 600; l++) begin
      @(posedge pclk);
      if (beeper_out !== b_prev) tog++;
      b_prev = beeper_out;
    end
    check("tone", 32'(tog >= 600 / HALF - 1 && tog <= 600 / HALF + 1), 32'h1);
    sel(1, 1, 1);
    check("beeper_out", 32'(beeper_out), 32'h1);
    check("continuity_enable", 32'(continuity_enable), 32'h0);
    continuity_below <= 0;
    sel(0, 1, 1);
    wait_conv(16'd777, 0);
    read_val(777);
    // Plane 1 high: lit ohms annunciators low, unlit high ohms one high
    for (i = 0; i < 1100 && backplane1_level !== LVL_HIGH; i++) @(posedge pclk);
    check("segment_line", 32'(segment_line[2:0]), 32'h4);
    wait_conv(16'd100, 0);
    wait_conv(16'd50, 1);
    read_val(50);
    sel(0, 0, 1);
    wait_conv(16'd5000, 0);
    check("overload", 32'(overload_indication), 32'h1);
    apb(REG_STATUS, 0, 32'h200, 32'h200, 0);
    sel(0, 1, 1);
    wait_conv(16'd555, 0);
    read_val(555);
    check("overload", 32'(overload_indication), 32'h0);
    sel(0, 1, 0);
    wait_conv(16'd3000, 0);
    read_val(555);
    close_out();
  end
endmodule

// File: meter_ohms_monitor.sv
`timescale 1ns/1ps
module meter_ohms_monitor import meter_pkg::*; #(
  parameter int INT_FINE = INT_FINE_TICKS,
  parameter int CRYS_HZ = CRYSTAL_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic function_high,
  input wire logic subrange_select_high,
  input wire logic subrange_select_low,
  input wire logic continuity_below,
  input wire logic offset_null_phase,
  input wire logic integrate_input,
  input wire logic deintegrate_pos,
  input wire logic deintegrate_neg,
  input wire logic fine_range,
  input wire logic low_known_resistor,
  input wire logic high_known_resistor,
  input wire logic continuity_enable,
  input wire logic beeper_out,
  input wire logic [1:0] backplane1_level,
  input wire logic [1:0] backplane2_level
);
  // ----
  // Helpers
  // ----
  localparam int TICK = 2 * PCLK_HZ / CRYS_HZ;
  localparam int TONE_MAX = TONE_HALF_TICKS * PCLK_HZ / CRYS_HZ + 4;
  logic deint;
  logic tone_on;
  logic beep_d;
  int still;
  int int_len;
  assign deint = deintegrate_pos | deintegrate_neg;
  assign tone_on = continuity_enable & continuity_below;
  // Tick phase is unknown, so lengths get one tick of slack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      still <= 0;
      int_len <= 0;
      beep_d <= 1'b1;
    end else begin
      still <= (tone_on && beeper_out == beep_d) ? still + 1 : 0;
      int_len <= integrate_input ? int_len + 1 : 0;
      beep_d <= beeper_out;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Checks
  // ----
  a_cont_gate: assert property (continuity_enable ==
    (function_high && !subrange_select_high && !subrange_select_low)) else $error("gate");
  a_beep_quiet: assert property (!tone_on |-> beeper_out) else $error("beep off");
  a_tone_runs: assert property (still <= TONE_MAX) else $error("tone stuck");
  a_known_low: assert property (low_known_resistor == (deint && function_high
    && !subrange_select_high && !subrange_select_low)) else $error("low known");
  a_known_high: assert property (high_known_resistor ==
    (deint && function_high && subrange_select_high)) else $error("high known");
  a_phase_excl: assert property ($onehot({offset_null_phase, integrate_input,
    deintegrate_pos, deintegrate_neg})) else $error("phase");
  a_null_next: assert property ($fell(offset_null_phase) |-> integrate_input)
    else $error("null order");
  a_int_next: assert property ($fell(integrate_input) |-> deint) else $error("int order");
  a_fine_len: assert property ($fell(integrate_input) && fine_range |->
    int_len >= INT_FINE * TICK - TICK && int_len <= INT_FINE * TICK + TICK) else $error("fine");
  a_coarse_len: assert property ($fell(integrate_input) && !fine_range |->
    int_len >= INT_COARSE_TICKS * TICK - TICK && int_len <= INT_COARSE_TICKS * TICK + TICK)
    else $error("coarse");
  a_bp_duplex: assert property (backplane1_level != 2'h3 && backplane2_level != 2'h3
    && (backplane1_level == LVL_MID || backplane2_level == LVL_MID)) else $error("planes");
  c_tone: cover property (tone_on ##1 $changed(beeper_out));
  c_fine: cover property ($fell(integrate_input) && fine_range);
  c_high: cover property (high_known_resistor);
endmodule

bind meter_ohms_mode_display_ctrl meter_ohms_monitor #(.INT_FINE(INT_FINE), .CRYS_HZ(CRYS_HZ))
  monitor (.pclk, .presetn, .function_high, .subrange_select_high, .subrange_select_low,
  .continuity_below, .offset_null_phase, .integrate_input, .deintegrate_pos,
  .deintegrate_neg, .fine_range, .low_known_resistor, .high_known_resistor,
  .continuity_enable, .beeper_out, .backplane1_level, .backplane2_level);

// File: meter_pkg.sv
package meter_pkg;

  // ---------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------
  localparam int PCLK_HZ = 20000000;
  localparam int CRYSTAL_HZ = 120000;
  localparam int TONE_CRYSTAL_DIV = 60;
  localparam int TONE_HALF_TICKS = TONE_CRYSTAL_DIV / 2;

  // ---------------------------------------------------------------
  // Conversion timing, in internal clock ticks
  // ---------------------------------------------------------------
  localparam int AZ_TICKS = 1000;
  localparam int INT_COARSE_TICKS = 1000;
  localparam int INT_FINE_TICKS = 10000;
  localparam logic [15:0] OVERLOAD_BCD = 16'h4000;
  localparam logic [15:0] UNDERRANGE_BCD = 16'h0360;

  // ---------------------------------------------------------------
  // Display
  // ---------------------------------------------------------------
  localparam int SEG_LINES = 18;
  localparam int LCD_SLOT_TICKS = 64;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_READING = 12'h008;
  localparam logic CTRL_DISPLAY_RESET = 1'b1;

  typedef enum logic [1:0] {T_HIGH, T_MID, T_LOW} tern_e;
  typedef enum logic [1:0] {PH_AZ, PH_INT, PH_DEINT} phase_e;

  function automatic tern_e tern_decode(input logic hi, input logic lo);
    if (hi) begin
      return T_HIGH;
    end else if (lo) begin
      return T_LOW;
    end
    return T_MID;
  endfunction

endpackage
